// ---- logic_ops_pkg.sv ----
package logic_ops_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BANK = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0c;
    localparam logic [7:0] OFS_STACK_TOP = 8'h10;
    localparam logic [7:0] OFS_REG_BASE = 8'h40;
    localparam logic [7:0] OFS_REG_LAST = 8'hbc;
    localparam logic [7:0] OFS_INDEX_BASE = 8'hc0;
    localparam logic [7:0] OFS_INDEX_LAST = 8'hcc;

    // ------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SRC_LSB = 3;
    localparam int CMD_DST_LSB = 8;
    localparam int CMD_TO_MEM_BIT = 13;
    localparam int CMD_INDEX_LSB = 14;
    localparam int CMD_MODE_LSB = 16;
    localparam int CMD_IMM_LSB = 18;

    // Status and bank fields
    localparam int STAT_FLAGS_LSB = 0;
    localparam int STAT_BANK_A_BIT = 4;
    localparam int STAT_BANK_B_BIT = 5;
    localparam int STAT_GIE_BIT = 6;
    localparam int STAT_DEPTH_LSB = 8;
    localparam int BANK_A_BIT = 0;
    localparam int BANK_B_BIT = 1;
    localparam int BANK_GIE_BIT = 2;

    // ------------------------------------------------------------
    // Reset values and register layout
    // ------------------------------------------------------------
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [4:0] ACC_REG = 5'h04;
    localparam int PHYS_REGS = 44;

    // Operations
    typedef enum logic [2:0] {
        OP_AND_WITH_ACCUMULATOR = 3'h0,
        OP_BIT_TEST = 3'h1,
        OP_COMPARE_IMMEDIATE = 3'h2,
        OP_COMPLEMENT_REGISTER = 3'h3,
        OP_CALL_RELATIVE = 3'h4
    } op_type;

    // Index register address modes
    typedef enum logic [1:0] {
        IDX_POST_DEC = 2'h0,
        IDX_NO_CHANGE = 2'h1,
        IDX_POST_INC = 2'h2,
        IDX_PRE_INC = 2'h3
    } index_mode_type;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } flags_type;

    typedef struct packed {
        logic [15:0] pc;
        flags_type flags;
        logic global_interrupt_enable;
        logic bank_a;
        logic bank_b;
    } stack_entry_type;

endpackage

// ---- logic_compare_call_ops.sv ----
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module logic_compare_call_ops
    import logic_ops_pkg::*;
#(
    parameter int STACK_DEPTH = 12
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_data_o
);

    // ------------------------------------------------------------
    // Bank mapping
    // ------------------------------------------------------------

    // Logical register to storage slot; slots 32..43 hold alternates
    function automatic logic [5:0] phys_index(input logic [4:0] r, input logic ba,
                                              input logic bb);
        logic [5:0] idx;
        idx = {1'b0, r};
        if (r < 5'd4 && ba)
        begin
            idx = 6'd32 + {1'b0, r};
        end
        else if (r >= 5'd4 && r < 5'd12 && bb)
        begin
            idx = 6'd32 + {1'b0, r};
        end
        return idx;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] regs_q [PHYS_REGS];
    logic [15:0] index_q [4];
    stack_entry_type stack_q [STACK_DEPTH];
    logic [$clog2(STACK_DEPTH+1)-1:0] depth_q;
    logic [$clog2(STACK_DEPTH)-1:0] sp_q;
    flags_type flags_q;
    logic bank_a_q;
    logic bank_b_q;
    logic gie_q;
    logic [15:0] pc_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic mem_we_q;
    logic [15:0] mem_addr_q;
    logic [7:0] mem_data_q;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic req;
    logic wr_fire;
    logic cmd_fire;
    logic reg_hit;
    logic index_hit;
    logic [4:0] reg_sel;
    logic [1:0] index_sel;
    logic [31:0] wmask;
    logic [31:0] wdata;

    // Writes land on the acknowledging edge only
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_fire = req & wb_we_i & ack_q;
    assign cmd_fire = wr_fire & (wb_adr_i == OFS_COMMAND) & (&wb_sel_i[3:0]);
    assign reg_hit = (wb_adr_i >= OFS_REG_BASE) && (wb_adr_i <= OFS_REG_LAST);
    assign index_hit = (wb_adr_i >= OFS_INDEX_BASE) && (wb_adr_i <= OFS_INDEX_LAST);
    assign reg_sel = 5'(8'(wb_adr_i - OFS_REG_BASE) >> 2);
    assign index_sel = 2'(8'(wb_adr_i - OFS_INDEX_BASE) >> 2);
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdata = wb_dat_i & wmask;

    // ------------------------------------------------------------
    // Command fields
    // ------------------------------------------------------------
    op_type op;
    logic [4:0] src;
    logic [4:0] dst;
    logic to_mem;
    logic [1:0] idx_sel;
    index_mode_type idx_mode;
    logic [7:0] imm;

    assign op = op_type'(wb_dat_i[CMD_OP_LSB +: 3]);
    assign src = wb_dat_i[CMD_SRC_LSB +: 5];
    assign dst = wb_dat_i[CMD_DST_LSB +: 5];
    assign to_mem = wb_dat_i[CMD_TO_MEM_BIT];
    assign idx_sel = wb_dat_i[CMD_INDEX_LSB +: 2];
    assign idx_mode = index_mode_type'(wb_dat_i[CMD_MODE_LSB +: 2]);
    assign imm = wb_dat_i[CMD_IMM_LSB +: 8];

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    logic [7:0] src_full;
    logic [7:0] src_limited;
    logic [7:0] acc;
    logic [7:0] and_acc;
    logic [7:0] and_imm;
    logic [8:0] diff;
    logic [7:0] complement_register;
    logic [15:0] pc_next;
    logic [15:0] call_target;
    logic [15:0] idx_now;
    logic [15:0] idx_addr;
    logic [15:0] idx_after;

    // Operand fetch through the active bank view
    assign src_full = regs_q[phys_index(src, bank_a_q, bank_b_q)];
    assign src_limited = regs_q[phys_index({1'b0, src[3:0]}, bank_a_q, bank_b_q)];
    assign acc = regs_q[phys_index(ACC_REG, bank_a_q, bank_b_q)];
    assign and_acc = src_full & acc;
    assign and_imm = src_limited & imm;
    assign diff = {1'b0, src_limited} - {1'b0, imm};
    assign complement_register = ~regs_q[phys_index(dst, bank_a_q, bank_b_q)];

    // Return address is the word after the call
    assign pc_next = 16'(pc_q + 16'h0001);
    assign call_target = 16'(pc_next + {{8{imm[7]}}, imm});

    // Index pointer address and update
    assign idx_now = index_q[idx_sel];
    assign idx_addr = (idx_mode == IDX_PRE_INC) ? 16'(idx_now + 16'h0001) : idx_now;
    always_comb
    begin
        unique case (idx_mode)
            IDX_POST_DEC: idx_after = 16'(idx_now - 16'h0001);
            IDX_NO_CHANGE: idx_after = idx_now;
            IDX_POST_INC: idx_after = 16'(idx_now + 16'h0001);
            IDX_PRE_INC: idx_after = 16'(idx_now + 16'h0001);
        endcase
    end

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------

    // One wait state; ack drops the cycle after it is given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data, captured as the ack is raised; unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dat_q <= 32'h0000_0000;
        end
        else if (req & ~ack_q)
        begin
            dat_q <= 32'h0000_0000;
            if (reg_hit)
            begin
                dat_q <= {24'h00_0000, regs_q[phys_index(reg_sel, bank_a_q, bank_b_q)]};
            end
            else if (index_hit)
            begin
                dat_q <= {16'h0000, index_q[index_sel]};
            end
            else
            begin
                unique case (wb_adr_i)
                    OFS_STATUS: dat_q <= 32'({depth_q, 1'b0, gie_q, bank_b_q, bank_a_q,
                                              flags_q} << STAT_FLAGS_LSB);
                    OFS_BANK: dat_q <= {29'h0000_0000, gie_q, bank_b_q, bank_a_q};
                    OFS_PC: dat_q <= {16'h0000, pc_q};
                    OFS_STACK_TOP: dat_q <= 32'(stack_q[sp_q]);
                    default: dat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------

    // Software window writes and op results share one writer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < PHYS_REGS; i++)
            begin
                regs_q[i] <= REG_RESET;
            end
        end
        else if (wr_fire & reg_hit & wb_sel_i[0])
        begin
            regs_q[phys_index(reg_sel, bank_a_q, bank_b_q)] <= wb_dat_i[7:0];
        end
        else if (cmd_fire)
        begin
            if (op == OP_AND_WITH_ACCUMULATOR && !to_mem)
            begin
                regs_q[phys_index(dst, bank_a_q, bank_b_q)] <= and_acc;
            end
            else if (op == OP_COMPLEMENT_REGISTER)
            begin
                regs_q[phys_index(dst, bank_a_q, bank_b_q)] <= complement_register;
            end
        end
    end

    // Bus writes set the index pointers; of the ops, only the memory form of the AND moves them
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 4; i++)
            begin
                index_q[i] <= 16'h0000;
            end
        end
        else if (wr_fire & index_hit)
        begin
            index_q[index_sel] <= wdata[15:0] | (index_q[index_sel] & ~wmask[15:0]);
        end
        else if (cmd_fire && op == OP_AND_WITH_ACCUMULATOR && to_mem)
        begin
            index_q[idx_sel] <= idx_after;
        end
    end

    // Data memory write port, one-cycle pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem_we_q <= 1'b0;
            mem_addr_q <= 16'h0000;
            mem_data_q <= 8'h00;
        end
        else
        begin
            mem_we_q <= cmd_fire && op == OP_AND_WITH_ACCUMULATOR && to_mem;
            if (cmd_fire && op == OP_AND_WITH_ACCUMULATOR && to_mem)
            begin
                mem_addr_q <= idx_addr;
                mem_data_q <= and_acc;
            end
        end
    end

    assign mem_we_o = mem_we_q;
    assign mem_addr_o = mem_addr_q;
    assign mem_data_o = mem_data_q;

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------

    // Each op touches only its own flags; call leaves them alone
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flags_q <= '0;
        end
        else if (cmd_fire)
        begin
            unique case (op)
                OP_AND_WITH_ACCUMULATOR:
                begin
                    flags_q.n <= and_acc[7];
                    flags_q.z <= (and_acc == 8'h00);
                end
                OP_BIT_TEST:
                begin
                    flags_q.n <= and_imm[7];
                    flags_q.z <= (and_imm == 8'h00);
                end
                OP_COMPARE_IMMEDIATE:
                begin
                    flags_q.n <= diff[7];
                    flags_q.z <= (diff[7:0] == 8'h00);
                    flags_q.c <= diff[8];
                    flags_q.v <= (src_limited[7] ^ imm[7]) & (src_limited[7] ^ diff[7]);
                end
                OP_COMPLEMENT_REGISTER:
                begin
                    flags_q.n <= complement_register[7];
                    flags_q.z <= (complement_register == 8'h00);
                end
                default:
                begin
                    flags_q <= flags_q;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bank selection and interrupt enable
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bank_a_q <= 1'b0;
            bank_b_q <= 1'b0;
            gie_q <= 1'b0;
        end
        else if (wr_fire && wb_adr_i == OFS_BANK && wb_sel_i[0])
        begin
            bank_a_q <= wb_dat_i[BANK_A_BIT];
            bank_b_q <= wb_dat_i[BANK_B_BIT];
            gie_q <= wb_dat_i[BANK_GIE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Program counter and address stack
    // ------------------------------------------------------------

    // Every executed op advances PC; a call branches instead
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pc_q <= PC_RESET;
        end
        else if (wr_fire && wb_adr_i == OFS_PC)
        begin
            pc_q <= wdata[15:0] | (pc_q & ~wmask[15:0]);
        end
        else if (cmd_fire)
        begin
            pc_q <= (op == OP_CALL_RELATIVE) ? call_target : pc_next;
        end
    end

    // Circular stack; a push past the depth overwrites the oldest entry
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sp_q <= '0;
            depth_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++)
            begin
                stack_q[i] <= '0;
            end
        end
        else if (cmd_fire && op == OP_CALL_RELATIVE)
        begin
            stack_q[(depth_q == 0) ? sp_q : 
                    ((sp_q == ($clog2(STACK_DEPTH))'(STACK_DEPTH - 1)) ? '0 :
                     ($clog2(STACK_DEPTH))'(sp_q + 1'b1))]
                <= '{pc: pc_next, flags: flags_q, global_interrupt_enable: gie_q,
                     bank_a: bank_a_q, bank_b: bank_b_q};
            if (depth_q != 0)
            begin
                sp_q <= (sp_q == ($clog2(STACK_DEPTH))'(STACK_DEPTH - 1)) ? '0 :
                        ($clog2(STACK_DEPTH))'(sp_q + 1'b1);
            end
            if (depth_q != ($clog2(STACK_DEPTH+1))'(STACK_DEPTH))
            begin
                depth_q <= ($clog2(STACK_DEPTH+1))'(depth_q + 1'b1);
            end
        end
    end

endmodule

`default_nettype wire

// ---- logic_compare_call_ops_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

module logic_compare_call_ops_asserts
    import logic_ops_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic mem_we_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [7:0] mem_data_o
);
    // ------------------------------------------------------------
    // Handshake sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Fresh request, not yet answered
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // Indexed store command accepted on this edge
    sequence s_mem_cmd;
        wb_ack_o && wb_we_i && wb_adr_i == OFS_COMMAND && wb_sel_i == 4'hf
            && wb_dat_i[CMD_TO_MEM_BIT]
            && wb_dat_i[CMD_OP_LSB +: 3] == 3'h0;
    endsequence

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_ack_delay;
        s_req |=> wb_ack_o;
    endproperty
    property p_ack_once;
        wb_ack_o |-> s_ack_pulse;
    endproperty
    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    // First edge out of reset must be quiet on every output except mem_data_o
    property p_reset_quiet;
        $past(rst_i) |-> !wb_ack_o && !mem_we_o && wb_dat_o == 32'h0 && mem_addr_o == 16'h0;
    endproperty
    property p_mem_pulse;
        mem_we_o |=> !mem_we_o;
    endproperty
    property p_mem_cause;
        s_mem_cmd |=> mem_we_o;
    endproperty
    // Address and data only move together with the strobe
    property p_mem_hold;
        !$past(rst_i) && ($changed(mem_addr_o) || $changed(mem_data_o)) |-> mem_we_o;
    endproperty
    property p_cmd_reads_zero;
        wb_ack_o && !wb_we_i && wb_adr_i == OFS_COMMAND |-> wb_dat_o == 32'h0;
    endproperty
    property p_unmapped_zero;
        wb_ack_o && !wb_we_i && wb_adr_i > 8'h10 && wb_adr_i < OFS_REG_BASE
            |-> wb_dat_o == 32'h0;
    endproperty

    a_ack_delay: assert property (p_ack_delay) else $error("ack late");
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
    a_mem_pulse: assert property (p_mem_pulse) else $error("memory strobe too long");
    a_mem_cause: assert property (p_mem_cause) else $error("memory store missing");
    a_mem_hold: assert property (p_mem_hold) else $error("memory bus moved alone");
    a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command read not 0");
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not 0");
endmodule

bind logic_compare_call_ops logic_compare_call_ops_asserts chk_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o),
    .mem_data_o(mem_data_o)
);

`default_nettype wire

// ---- logic_compare_call_ops_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module logic_compare_call_ops_tb
    import logic_ops_pkg::*;
;
    logic clk_i, rst_i, cyc, stb, we, ack, mem_we;
    logic [7:0] adr, mem_data;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [15:0] mem_addr;
    logic [3:0] ef;
    int failures, comparisons;

    logic_compare_call_ops #(.STACK_DEPTH(12)) dut_u (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(wdat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .mem_we_o(mem_we),
        .mem_addr_o(mem_addr),
        .mem_data_o(mem_data)
    );

    // ------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Whole run needs a few hundred cycles; generous margin
    initial
    begin
        repeat (5000) @(posedge clk_i);
        failures++;
        wrap_up;
    end

    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task wrap_up;
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Ack and read data taken at the rising edge itself, released right after it
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
            failures++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(name, exp, q);
    endtask

    function automatic logic [7:0] ra(input int n);
        return OFS_REG_BASE + 8'(n * 4);
    endfunction

    function automatic logic [31:0] cmd(input op_type op, input int s, input int d,
        input logic tm, input int ix, input int md, input logic [7:0] imm);
        logic [31:0] c;
        c = 32'h0;
        c[CMD_OP_LSB +: 3] = op;
        c[CMD_SRC_LSB +: 5] = 5'(s);
        c[CMD_DST_LSB +: 5] = 5'(d);
        c[CMD_TO_MEM_BIT] = tm;
        c[CMD_INDEX_LSB +: 2] = 2'(ix);
        c[CMD_MODE_LSB +: 2] = 2'(md);
        c[CMD_IMM_LSB +: 8] = imm;
        return c;
    endfunction

    // Strobe is expected in the cycle right after the command ack
    task mem_chk(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_i);
        chk("mem_we", 32'h1, {31'h0, mem_we});
        chk("mem_addr", {16'h0, a}, {16'h0, mem_addr});
        chk("mem_data", {24'h0, d}, {24'h0, mem_data});
        @(negedge clk_i);
        chk("mem_we drop", 32'h0, {31'h0, mem_we});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd_chk("status", OFS_STATUS, 32'h0);
        rd_chk("pc", OFS_PC, 32'h0);
        rd_chk("command", OFS_COMMAND, 32'h0);
        wr(8'h20, 32'h55);
        rd_chk("unmapped", 8'h20, 32'h0);
    endtask

    // Source field 19 must fold onto R3, never reach R19
    task t_compare;
        logic [7:0] rv [4];
        logic [7:0] iv [4];
        logic [3:0] fv [4];
        rv = '{8'h05, 8'h03, 8'h80, 8'h7f};
        iv = '{8'h05, 8'h05, 8'h01, 8'hff};
        // Expected {N,Z,C,V}: equal, borrow, signed overflow, overflow with borrow
        fv = '{4'h4, 4'ha, 4'h1, 4'hb};
        wr(ra(19), 32'hee);
        for (int k = 0; k < 4; k++)
        begin
            wr(ra(3), {24'h0, rv[k]});
            wr(OFS_COMMAND, cmd(OP_COMPARE_IMMEDIATE, 19, 0, 1'b0, 0, 0, iv[k]));
            ef = fv[k];
            rd_chk("cmp flags", OFS_STATUS, {28'h0, ef});
            rd_chk("cmp source kept", ra(3), {24'h0, rv[k]});
        end
        rd_chk("cmp no store", ra(0), 32'h0);
        rd_chk("upper reg kept", ra(19), 32'hee);
    endtask

    task t_bit;
        wr(ra(2), 32'ha5);
        wr(OFS_COMMAND, cmd(OP_BIT_TEST, 18, 0, 1'b0, 0, 0, 8'h5a));
        rd_chk("bit flags zero", OFS_STATUS, {28'h0, 2'b01, ef[1:0]});
        wr(OFS_COMMAND, cmd(OP_BIT_TEST, 2, 0, 1'b0, 0, 0, 8'h80));
        rd_chk("bit flags neg", OFS_STATUS, {28'h0, 2'b10, ef[1:0]});
        rd_chk("bit source kept", ra(2), 32'ha5);
    endtask

    task t_cpl;
        wr(ra(20), 32'hff);
        wr(OFS_COMMAND, cmd(OP_COMPLEMENT_REGISTER, 0, 20, 1'b0, 0, 0, 8'h00));
        rd_chk("cpl value", ra(20), 32'h00);
        rd_chk("cpl flags", OFS_STATUS, {28'h0, 2'b01, ef[1:0]});
        wr(OFS_COMMAND, cmd(OP_COMPLEMENT_REGISTER, 0, 20, 1'b0, 0, 0, 8'h00));
        rd_chk("cpl again", ra(20), 32'hff);
    endtask

    task t_and;
        wr(ra(4), 32'h3c);
        wr(ra(10), 32'hf0);
        wr(OFS_COMMAND, cmd(OP_AND_WITH_ACCUMULATOR, 10, 21, 1'b0, 0, 0, 8'h00));
        rd_chk("and main acc", ra(21), 32'h30);
        wr(OFS_BANK, 32'h2);
        wr(ra(4), 32'h1f);
        wr(ra(23), 32'haa);
        wr(OFS_COMMAND, cmd(OP_AND_WITH_ACCUMULATOR, 21, 22, 1'b0, 0, 0, 8'h00));
        rd_chk("and alt acc", ra(22), 32'h10);
        wr(OFS_INDEX_BASE, 32'h1000);
        wr(OFS_INDEX_BASE + 8'h04, 32'h2000);
        wr(OFS_COMMAND, cmd(OP_AND_WITH_ACCUMULATOR, 23, 0, 1'b1, 0, 2, 8'h00));
        mem_chk(16'h1000, 8'h0a);
        wr(OFS_COMMAND, cmd(OP_AND_WITH_ACCUMULATOR, 23, 0, 1'b1, 1, 3, 8'h00));
        mem_chk(16'h2001, 8'h0a);
        rd_chk("post inc", OFS_INDEX_BASE, 32'h1001);
        rd_chk("pre inc", OFS_INDEX_BASE + 8'h04, 32'h2001);
        rd_chk("and flags", OFS_STATUS, {28'h0, 2'b00, ef[1:0]} | 32'h20);
        wr(OFS_BANK, 32'h0);
        rd_chk("main acc kept", ra(4), 32'h3c);
    endtask

    // Backward reach at its limit, then forward at its limit
    task t_call;
        wr(OFS_BANK, 32'h7);
        wr(OFS_PC, 32'h0100);
        wr(OFS_COMMAND, cmd(OP_CALL_RELATIVE, 0, 0, 1'b0, 0, 0, 8'h80));
        rd_chk("call back pc", OFS_PC, 32'h0081);
        rd_chk("stack top", OFS_STACK_TOP, {9'h0, 16'h0101, ef, 3'b111});
        rd_chk("depth one", OFS_STATUS, {16'h0, 8'h01, 4'h7, ef});
        wr(OFS_BANK, 32'h0);
        wr(OFS_COMMAND, cmd(OP_CALL_RELATIVE, 0, 0, 1'b0, 0, 0, 8'h7f));
        rd_chk("call fwd pc", OFS_PC, 32'h0101);
        rd_chk("stack top 2", OFS_STACK_TOP, {9'h0, 16'h0082, ef, 3'b000});
        rd_chk("depth two", OFS_STATUS, {16'h0, 8'h02, 4'h0, ef});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hf;
        wdat = 32'h0;
        ef = 4'h0;
        failures = 0;
        comparisons = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_compare;
        t_bit;
        t_cpl;
        ef[3:2] = 2'b00;
        t_and;
        t_call;
        wrap_up;
    end
endmodule

`default_nettype wire
